// *** hdl/reset_source_control.sv ***
// Reset source controller: pin, power-on and brown-out resets with cause register on APB
//
// Notes on behaviour
// R1: Interrupt priority enable bit selects priority levels or single-level scheme.
// R2: Software brown-out enable acts only with configuration 01; otherwise reads zero.
// R3: Software brown-out enable resets to one only under software configuration.
// R4: Executed reset instruction clears its flag; only firmware sets it again; the code also sets it on power-on reset.
// R5: Watchdog flag set by power-up, clear-watchdog or halt; cleared by time-out.
// R6: Halt-seen flag set by power-up or clear-watchdog; cleared by halt.
// R7: Power-on flag cleared by power-on reset only; never set by hardware.
// R8: Brown-out reset clears the brown-out flag; only firmware sets it again.
// R9: Five low flags cleared by events, set by software, identify last reset; the code lets software write only bits 4, 1 and 0.
// R10: Software should set the power-on flag after detecting a power-on reset.
// R11: Software reads brown-out when brown-out flag is 0 and power-on flag 1.
// R12: Holding the reset pin low resets; short pulses are filtered out.
// R13: Reset pin is never driven low; it stays an input.
// R14: With pin reset disabled, pin is a plain digital input without reset.
// R15: On-chip power-on pulse places the device in reset.
// R16: Enabled brown-out resets when supply low lasts beyond the filter time.
// R17: Device stays in brown-out reset while the supply stays low.
// R18: Enabled power-up timer holds reset a further delay after supply recovers.
// R19: Supply low during power-up timer re-enters brown-out and restarts timer.
// R20: Brown-out enable and power-up timer enable are configured independently.
// R21: Configuration 10 enables brown-out in run and idle, disables in sleep.
// R22: Configuration 11 always enables brown-out; software cannot turn it off.
// R23: Power-up timer is an eleven-bit RC-clocked counter of 2048 periods.
// R24: Async reset sources assert the reset and release through two-stage synchroniser.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module reset_source_control (
    input  wire logic        clk,                // System clock, 125 MHz
    input  wire logic        rst_n,              // Synchronous reset, active low
    input  wire logic        psel,               // APB select
    input  wire logic        penable,            // APB access phase
    input  wire logic        pwrite,             // APB write
    input  wire logic [11:0] paddr,              // APB byte address
    input  wire logic [31:0] pwdata,             // APB write data
    output logic      [31:0] prdata,             // APB read data
    output logic             pready,             // APB ready
    output logic             pslverr,            // APB error on unmapped address
    input  wire logic        extResetN,          // Reset pin, asynchronous
    input  wire logic        powerOnPulse,       // On-chip power-on pulse, asynchronous
    input  wire logic        supplyLow,          // Supply below brown-out threshold, asynchronous
    input  wire logic        rcClock,            // Internal RC oscillator, sampled
    input  wire logic [1:0]  brownoutCfg,        // Brown-out configuration field
    input  wire logic        extResetPinEn,      // Pin reset function enable
    input  wire logic        powerupTimerEn,     // Power-up timer enable
    input  wire logic        sleepMode,          // Device is in sleep
    input  wire logic        resetInstrExec,     // Reset instruction executed, pulse
    input  wire logic        watchdogTimeout,    // Watchdog time-out, pulse
    input  wire logic        clearWatchdogInstr, // Clear-watchdog instruction, pulse
    input  wire logic        haltInstr,          // Halt instruction, pulse
    output logic             deviceResetN,       // Device reset, active low
    output logic             irqPriorityEn,      // Interrupt priority scheme select
    output logic             brownoutDetectEn,   // Brown-out detector enable
    output logic             pinDigitalIn,       // Pin level when used as digital input
    output logic             extResetOe          // Reset pin output enable, always low
);

    // Effective brown-out enable for a configuration, software bit and sleep state
    function automatic logic borEnabled(input logic [1:0] cfg, input logic swEn, input logic slp);
        logic en;
        en = 1'b0;
        unique case (cfg)
            reset_source_pkg::BOR_CFG_OFF:   en = 1'b0;
            reset_source_pkg::BOR_CFG_SW:    en = swEn;    // [R2]
            reset_source_pkg::BOR_CFG_NOSLP: en = !slp;    // [R21]
            reset_source_pkg::BOR_CFG_ON:    en = 1'b1;    // [R22]
        endcase
        return en;
    endfunction : borEnabled

    reset_source_pkg::reset_cause_control_t      reset_cause_control_reg;
    reset_source_pkg::bor_state_t borState_reg;
    logic [1:0]                   syncReg [reset_source_pkg::NSYNC];
    logic [reset_source_pkg::NSYNC-1:0] syncOut;
    logic                         rcPrev_reg;
    logic                         rcEdge;
    logic [reset_source_pkg::FILT_W-1:0] pinFilt_reg;
    logic [reset_source_pkg::FILT_W-1:0] borFilt_reg;
    logic                         pinReset_reg;
    logic [reset_source_pkg::POWERUP_TIMER_W-1:0] pwrtCnt_reg;
    logic                         porPrev_reg;
    logic                         borEn;
    logic                         apbAccess;
    logic                         apbDone;
    logic                         rconSel;
    logic                         statusSel;
    logic                         rconWrite;
    logic                         anyReset;

    // Two-flop synchronisers for every asynchronous input
    genvar gi;
    generate
        for (gi = 0; gi < reset_source_pkg::NSYNC; gi++) begin : g_sync
            logic rawIn;
            assign rawIn = (gi == reset_source_pkg::SY_PIN) ? extResetN :
                           (gi == reset_source_pkg::SY_POR) ? powerOnPulse :
                           (gi == reset_source_pkg::SY_LOW) ? supplyLow : rcClock;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    syncReg[gi] <= {2{reset_source_pkg::SYNC_INIT[gi]}};
                end else begin
                    syncReg[gi] <= {syncReg[gi][0], rawIn};   // [R24]
                end
            end
            assign syncOut[gi] = syncReg[gi][1];
        end
    endgenerate

    // RC clock edge from the second synchroniser stage only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rcPrev_reg <= 1'b0;
        end else begin
            rcPrev_reg <= syncOut[reset_source_pkg::SY_RC];
        end
    end
    assign rcEdge = syncOut[reset_source_pkg::SY_RC] && !rcPrev_reg;

    // Brown-out enable decode shared by detector and status read
    assign borEn = borEnabled(brownoutCfg, reset_cause_control_reg.swBrownoutEn, sleepMode);

    // Pin noise filter: reset only after a sustained low level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinFilt_reg  <= '0;
            pinReset_reg <= 1'b0;
        end else if (!extResetPinEn || syncOut[reset_source_pkg::SY_PIN]) begin
            pinFilt_reg  <= '0;                                        // [R14]
            pinReset_reg <= 1'b0;
        end else if (pinFilt_reg == reset_source_pkg::FILT_W'(reset_source_pkg::EXT_FILTER_CYC - 1)) begin
            pinReset_reg <= 1'b1;                                      // [R12]
        end else begin
            pinFilt_reg  <= pinFilt_reg + 1'b1;
        end
    end

    // Brown-out detector and power-up timer sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            borState_reg <= reset_source_pkg::ST_RUN;
            borFilt_reg  <= '0;
            pwrtCnt_reg  <= reset_source_pkg::POWERUP_TIMER_ZERO;
            porPrev_reg  <= 1'b1;
        end else begin
            porPrev_reg <= syncOut[reset_source_pkg::SY_POR];
            unique case (borState_reg)
                reset_source_pkg::ST_RUN: begin
                    pwrtCnt_reg <= reset_source_pkg::POWERUP_TIMER_ZERO;
                    if (!borEn || !syncOut[reset_source_pkg::SY_LOW]) begin
                        borFilt_reg <= '0;
                        if (porPrev_reg && !syncOut[reset_source_pkg::SY_POR] && powerupTimerEn) begin
                            borState_reg <= reset_source_pkg::ST_POWERUP_TIMER;   // Timer after power-on pulse
                        end
                    end else if (borFilt_reg ==
                                 reset_source_pkg::FILT_W'(reset_source_pkg::BROWNOUT_FILTER_CYC - 1)) begin
                        borState_reg <= reset_source_pkg::ST_BROWNOUT; // [R16]
                    end else begin
                        borFilt_reg <= borFilt_reg + 1'b1;
                    end
                end
                reset_source_pkg::ST_BROWNOUT: begin
                    borFilt_reg <= '0;
                    pwrtCnt_reg <= reset_source_pkg::POWERUP_TIMER_ZERO;
                    if (!syncOut[reset_source_pkg::SY_LOW]) begin
                        borState_reg <= powerupTimerEn ? reset_source_pkg::ST_POWERUP_TIMER   // [R18] [R20]
                                                       : reset_source_pkg::ST_RUN;
                    end                                                              // [R17]
                end
                reset_source_pkg::ST_POWERUP_TIMER: begin
                    borFilt_reg <= '0;
                    if (syncOut[reset_source_pkg::SY_LOW] && borEn) begin
                        borState_reg <= reset_source_pkg::ST_BROWNOUT;             // [R19]
                        pwrtCnt_reg  <= reset_source_pkg::POWERUP_TIMER_ZERO;
                    end else if (rcEdge) begin
                        if (pwrtCnt_reg == reset_source_pkg::POWERUP_TIMER_LAST) begin
                            borState_reg <= reset_source_pkg::ST_RUN;              // [R23]
                        end
                        pwrtCnt_reg <= pwrtCnt_reg + 1'b1;
                    end
                end
                default: begin
                    borState_reg <= reset_source_pkg::ST_RUN;
                end
            endcase
        end
    end

    // APB decode
    assign apbAccess = psel && penable;
    assign apbDone   = apbAccess && pready;
    assign rconSel   = (paddr == reset_source_pkg::RESET_CAUSE_CONTROL_OFFSET);
    assign statusSel = (paddr == reset_source_pkg::STATUS_OFFSET);
    assign rconWrite = apbDone && pwrite && rconSel;

    // APB answer: one wait state, registered data and error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= reset_source_pkg::DATA_ZERO;
        end else if (apbAccess && !pready) begin
            pready  <= 1'b1;
            pslverr <= !(rconSel || statusSel);
            if (pwrite || !(rconSel || statusSel)) begin
                prdata <= reset_source_pkg::DATA_ZERO;
            end else if (rconSel) begin
                prdata <= {24'h000000, reset_cause_control_reg.irqPriorityEn,
                           reset_cause_control_reg.swBrownoutEn && (brownoutCfg == reset_source_pkg::BOR_CFG_SW),  // [R2]
                           1'b0, reset_cause_control_reg[4:0]};                                                   // [R9]
            end else begin
                prdata <= {24'h000000, 1'b0, brownoutCfg, borEn, pinReset_reg,
                           syncOut[reset_source_pkg::SY_PIN], borState_reg};
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= reset_source_pkg::DATA_ZERO;
        end
    end

    // Control bits of the cause register
    always_ff @(posedge clk) begin
        if (!rst_n || syncOut[reset_source_pkg::SY_POR]) begin
            reset_cause_control_reg.irqPriorityEn <= reset_source_pkg::RESET_CAUSE_CONTROL_POR.irqPriorityEn;
            reset_cause_control_reg.swBrownoutEn  <= (brownoutCfg == reset_source_pkg::BOR_CFG_SW);          // [R3]
            reset_cause_control_reg.unused5       <= 1'b0;
        end else if (rconWrite) begin
            reset_cause_control_reg.irqPriorityEn <= pwdata[reset_source_pkg::IRQ_PRIO_BIT];                 // [R1]
            if (brownoutCfg == reset_source_pkg::BOR_CFG_SW) begin
                reset_cause_control_reg.swBrownoutEn <= pwdata[reset_source_pkg::SW_BOR_BIT];               // [R2]
            end
        end
    end

    // Reset event flags: hardware events win over a software write
    always_ff @(posedge clk) begin
        if (!rst_n || syncOut[reset_source_pkg::SY_POR]) begin
            reset_cause_control_reg.resetInstrFlag      <= reset_source_pkg::RESET_CAUSE_CONTROL_POR.resetInstrFlag;
            reset_cause_control_reg.watchdogExpiredFlag <= reset_source_pkg::RESET_CAUSE_CONTROL_POR.watchdogExpiredFlag;  // [R5]
            reset_cause_control_reg.haltSeenFlag        <= reset_source_pkg::RESET_CAUSE_CONTROL_POR.haltSeenFlag;         // [R6]
            reset_cause_control_reg.powerOnFlag         <= reset_source_pkg::RESET_CAUSE_CONTROL_POR.powerOnFlag;          // [R7] [R15]
            reset_cause_control_reg.brownoutFlag        <= reset_source_pkg::RESET_CAUSE_CONTROL_POR.brownoutFlag;
        end else begin
            if (resetInstrExec) begin
                reset_cause_control_reg.resetInstrFlag <= 1'b0;                                  // [R4]
            end else if (rconWrite) begin
                reset_cause_control_reg.resetInstrFlag <= pwdata[reset_source_pkg::RI_BIT];
            end
            if (watchdogTimeout) begin
                reset_cause_control_reg.watchdogExpiredFlag <= 1'b0;                             // [R5]
            end else if (clearWatchdogInstr || haltInstr) begin
                reset_cause_control_reg.watchdogExpiredFlag <= 1'b1;
            end
            if (clearWatchdogInstr) begin
                reset_cause_control_reg.haltSeenFlag <= 1'b1;                                    // [R6]
            end else if (haltInstr) begin
                reset_cause_control_reg.haltSeenFlag <= 1'b0;
            end
            if (rconWrite) begin
                reset_cause_control_reg.powerOnFlag <= pwdata[reset_source_pkg::PORF_BIT];       // [R7]
            end
            if (borState_reg == reset_source_pkg::ST_BROWNOUT) begin
                reset_cause_control_reg.brownoutFlag <= 1'b0;                                    // [R8]
            end else if (rconWrite) begin
                reset_cause_control_reg.brownoutFlag <= pwdata[reset_source_pkg::BOR_BIT];
            end
        end
    end

    // Combined reset request, released through the synchronised sources
    assign anyReset = syncOut[reset_source_pkg::SY_POR] || pinReset_reg ||
                      (borState_reg != reset_source_pkg::ST_RUN) || resetInstrExec || watchdogTimeout;

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            deviceResetN     <= 1'b0;
            irqPriorityEn    <= 1'b0;
            brownoutDetectEn <= 1'b0;
            pinDigitalIn     <= 1'b1;
            extResetOe       <= 1'b0;
        end else begin
            deviceResetN     <= !anyReset;                     // [R15] [R24]
            irqPriorityEn    <= reset_cause_control_reg.irqPriorityEn;        // [R1]
            brownoutDetectEn <= borEn;                         // [R21] [R22]
            pinDigitalIn     <= syncOut[reset_source_pkg::SY_PIN];
            extResetOe       <= 1'b0;                          // [R13]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pin_never_driven: assert property (!extResetOe) else $error("reset pin driven"); // [R13]
    a_sbo_reads_zero: assert property (apbDone && !pwrite && rconSel && brownoutCfg != reset_source_pkg::BOR_CFG_SW
        |-> !prdata[reset_source_pkg::SW_BOR_BIT])
        else $error("software brown-out bit not zero"); // [R2]
    a_bor_flag_clear: assert property (borState_reg == reset_source_pkg::ST_BROWNOUT |=> !reset_cause_control_reg.brownoutFlag)
        else $error("brown-out flag not cleared"); // [R8]
    a_por_flag_clear: assert property (syncOut[reset_source_pkg::SY_POR] |=> !reset_cause_control_reg.powerOnFlag)
        else $error("power-on flag not cleared"); // [R7]
    a_instr_flag_clear: assert property (resetInstrExec && !syncOut[reset_source_pkg::SY_POR]
        |=> !reset_cause_control_reg.resetInstrFlag) else $error("reset instruction flag kept"); // [R4]
    a_halt_pd_clear: assert property (haltInstr && !clearWatchdogInstr && !syncOut[reset_source_pkg::SY_POR]
        |=> !reset_cause_control_reg.haltSeenFlag && reset_cause_control_reg.watchdogExpiredFlag == !$past(watchdogTimeout))
        else $error("halt flags wrong"); // [R6]
    a_wdt_flag_clear: assert property (watchdogTimeout && !syncOut[reset_source_pkg::SY_POR]
        |=> !reset_cause_control_reg.watchdogExpiredFlag) else $error("watchdog flag kept"); // [R5]
    a_bor_holds_reset: assert property (borState_reg == reset_source_pkg::ST_BROWNOUT |=> !deviceResetN)
        else $error("brown-out not holding reset"); // [R17]
    a_powerup_timer_restart: assert property (borState_reg == reset_source_pkg::ST_POWERUP_TIMER && syncOut[reset_source_pkg::SY_LOW]
        && borEn |=> borState_reg == reset_source_pkg::ST_BROWNOUT && pwrtCnt_reg == reset_source_pkg::POWERUP_TIMER_ZERO)
        else $error("power-up timer not restarted"); // [R19]
    a_pin_disabled: assert property (!extResetPinEn |=> !pinReset_reg)
        else $error("disabled pin reset"); // [R14]
    a_prio_follows: assert property (rconWrite |=> ##1 irqPriorityEn == $past(pwdata[7], 2))
        else $error("priority enable not updated"); // [R1]

    c_brownout: cover property (borState_reg == reset_source_pkg::ST_POWERUP_TIMER ##1
        borState_reg == reset_source_pkg::ST_BROWNOUT);
    c_powerup_timer_done: cover property (borState_reg == reset_source_pkg::ST_POWERUP_TIMER ##1 borState_reg == reset_source_pkg::ST_RUN);
    c_pin_reset: cover property ($rose(pinReset_reg));
    c_reset_cause_control_read: cover property (apbDone && !pwrite && rconSel);

endmodule : reset_source_control

// *** hdl/reset_source_pkg.sv ***
// Package holding constants and types shared by the reset source controller
package reset_source_pkg;

    // Clock rate and derived timing
    localparam int CLK_PERIOD_NS       = 8;
    localparam int EXT_FILTER_NS       = 100;   // Shortest pin low pulse taken as a reset
    localparam int BROWNOUT_FILTER_NS  = 200;   // Supply low time before brown-out reset
    localparam int EXT_FILTER_CYC      = (EXT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BROWNOUT_FILTER_CYC = (BROWNOUT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W              = 8;

    // Power-up timer: eleven-bit counter of RC periods
    localparam int           POWERUP_TIMER_W        = 11;
    localparam logic [10:0]  POWERUP_TIMER_LAST     = 11'h7FF;   // 2048 periods, 0..2047
    localparam logic [10:0]  POWERUP_TIMER_ZERO     = 11'h000;

    // APB register map (byte addresses)
    localparam int           ADDR_W        = 12;
    localparam logic [11:0]  RESET_CAUSE_CONTROL_OFFSET   = 12'h000;
    localparam logic [11:0]  STATUS_OFFSET = 12'h004;
    localparam logic [31:0]  DATA_ZERO     = 32'h0000_0000;

    // Brown-out configuration field encodings
    localparam logic [1:0]   BOR_CFG_OFF   = 2'h0;
    localparam logic [1:0]   BOR_CFG_SW    = 2'h1;
    localparam logic [1:0]   BOR_CFG_NOSLP = 2'h2;
    localparam logic [1:0]   BOR_CFG_ON    = 2'h3;

    // Bit positions in the reset cause register
    localparam int IRQ_PRIO_BIT = 7;
    localparam int SW_BOR_BIT   = 6;
    localparam int RI_BIT       = 4;
    localparam int BOR_BIT      = 0;
    localparam int PORF_BIT     = 1;

    // Synchroniser lanes for asynchronous inputs
    localparam int          NSYNC     = 4;
    localparam int          SY_PIN    = 0;
    localparam int          SY_POR    = 1;
    localparam int          SY_LOW    = 2;
    localparam int          SY_RC     = 3;
    localparam logic [3:0]  SYNC_INIT = 4'h3;   // Pin idle high, power-on pulse high

    // Reset cause and control register layout
    typedef struct packed {
        logic irqPriorityEn;
        logic swBrownoutEn;
        logic unused5;
        logic resetInstrFlag;
        logic watchdogExpiredFlag;
        logic haltSeenFlag;
        logic powerOnFlag;
        logic brownoutFlag;
    } reset_cause_control_t;

    // Value loaded on power-on with software brown-out control off
    localparam reset_cause_control_t RESET_CAUSE_CONTROL_POR = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    // Reset sequencer states
    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_BROWNOUT = 2'b01,
        ST_POWERUP_TIMER     = 2'b10
    } bor_state_t;

endpackage : reset_source_pkg

// *** test/supply_pin_model.sv ***
// Board reset pin with pull-up, supply comparator and RC oscillator
`timescale 1ns/10ps
module supply_pin_model (
    input  wire logic pinLowCmd,    // Pin held low from outside
    input  wire logic supplyCmd,    // Supply dipped below threshold
    input  wire logic porCmd,       // Supply ramp from zero
    output logic      extResetN,    // Reset pin level
    output logic      supplyLow,    // Comparator output
    output logic      powerOnPulse, // On-chip power-on pulse
    output logic      rcClock       // Free-running RC oscillator
);
    // Pin is only pulled low from outside; released it returns to the pull-up
    assign extResetN = pinLowCmd ? 1'b0 : 1'b1;
    assign supplyLow = supplyCmd;
    assign powerOnPulse = porCmd;
    // RC oscillator, 40 ns period, phase unrelated to the system clock
    initial begin
        rcClock = 1'b0;
        #3;
        forever #20 rcClock = ~rcClock;
    end
endmodule : supply_pin_model

// *** test/tb_top.sv ***
// Testbench for the reset source controller
`timescale 1ns/10ps
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, sawRst;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic extResetN, powerOnPulse, supplyLow, rcClock, pinLowCmd, supplyCmd, porCmd, extResetPinEn;
    logic [1:0] brownoutCfg;
    logic powerupTimerEn, sleepMode, resetInstrExec, watchdogTimeout, clearWatchdogInstr, haltInstr;
    logic deviceResetN, irqPriorityEn, brownoutDetectEn, pinDigitalIn, extResetOe;
    int   errors = 0;
    int   checks_done = 0;
    int   n;
    reset_source_control i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .extResetN, .powerOnPulse, .supplyLow, .rcClock, .brownoutCfg, .extResetPinEn, .powerupTimerEn,
        .sleepMode, .resetInstrExec, .watchdogTimeout, .clearWatchdogInstr, .haltInstr, .deviceResetN,
        .irqPriorityEn, .brownoutDetectEn, .pinDigitalIn, .extResetOe);
    supply_pin_model i_far (.pinLowCmd, .supplyCmd, .porCmd, .extResetN, .supplyLow, .powerOnPulse, .rcClock);
    task automatic conclude;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask : cyc
    // One-cycle event pulse: 3 halt, 2 watchdog time-out, 1 clear-watchdog, 0 reset instruction
    task automatic pulse(input int k);
        {haltInstr, watchdogTimeout, clearWatchdogInstr, resetInstrExec} <= 4'h1 << k;
        @(posedge clk);
        {haltInstr, watchdogTimeout, clearWatchdogInstr, resetInstrExec} <= 4'h0;
        cyc(2);
    endtask : pulse
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (t >= 50) begin
            errors++;
            conclude();
        end
    endtask : apb
    // Waits for the device to leave reset, count kept in n
    task automatic wait_run(input int lim);
        for (n = 0; n < lim && deviceResetN !== 1'b1; n++) @(posedge clk);
        if (n >= lim) begin
            errors++;
            conclude();
        end
    endtask : wait_run
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h5C);
        apb(1'b1, 12'h000, 32'hFF); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hDF);
        chk(irqPriorityEn, 1'b1);
        apb(1'b0, 12'h008, 32'h0); chk(err, 1'b1);
        apb(1'b1, 12'h000, 32'h9F); cyc(3); chk(brownoutDetectEn, 1'b0);
        supplyCmd <= 1'b1; sawRst = 1'b0; cyc(60); supplyCmd <= 1'b0; chk(sawRst, 1'b0);
    endtask : t_regs
    task automatic t_cfg;
        for (int c = 0; c < 4; c++) for (int s = 0; s < 2; s++) begin
            brownoutCfg <= c[1:0]; sleepMode <= s[0];
            if (c == 3) apb(1'b1, 12'h000, 32'h9F);
            cyc(4); chk(brownoutDetectEn, c == 3 || (c == 2 && s == 0));
            apb(1'b0, 12'h000, 32'h0); chk(rd[6], 1'b0);
        end
        {brownoutCfg, sleepMode} <= 3'b010; apb(1'b1, 12'h000, 32'hDF); cyc(3); chk(brownoutDetectEn, 1'b1);
    endtask : t_cfg
    task automatic t_pin;
        sawRst = 1'b0; pinLowCmd <= 1'b1; cyc(5); pinLowCmd <= 1'b0; cyc(20); chk(sawRst, 1'b0);
        pinLowCmd <= 1'b1; cyc(40); chk(deviceResetN, 1'b0); chk(extResetOe, 1'b0);
        pinLowCmd <= 1'b0; wait_run(20); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hDF);
        extResetPinEn <= 1'b0; sawRst = 1'b0; pinLowCmd <= 1'b1; cyc(40); chk(pinDigitalIn, 1'b0);
        chk(sawRst, 1'b0); pinLowCmd <= 1'b0; extResetPinEn <= 1'b1; cyc(5);
    endtask : t_pin
    task automatic t_flags;
        pulse(3); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hDB);
        pulse(2); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hD3);
        pulse(1); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hDF);
        pulse(0); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hCF);
        apb(1'b1, 12'h000, 32'hD3); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hDF);
    endtask : t_flags
    task automatic t_bor;
        supplyCmd <= 1'b1; cyc(60); chk(deviceResetN, 1'b0); apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'hDE); cyc(100); chk(deviceResetN, 1'b0);
        supplyCmd <= 1'b0; wait_run(20); apb(1'b1, 12'h000, 32'hDF);
        powerupTimerEn <= 1'b1; supplyCmd <= 1'b1; cyc(60); supplyCmd <= 1'b0; cyc(2000);
        chk(deviceResetN, 1'b0); supplyCmd <= 1'b1; cyc(40); supplyCmd <= 1'b0;
        wait_run(12000); chk(n >= 10220 && n <= 10280, 1'b1);
        apb(1'b0, 12'h000, 32'h0); chk(rd[1:0], 2'b10);
        apb(1'b1, 12'h000, 32'hDF); powerupTimerEn <= 1'b0;
    endtask : t_bor
    task automatic t_por;
        porCmd <= 1'b1; cyc(10); chk(deviceResetN, 1'b0); porCmd <= 1'b0;
        wait_run(20); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h5C);
    endtask : t_por
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Remembers any device reset since last cleared
    always @(posedge clk) if (deviceResetN === 1'b0) sawRst <= 1'b1;
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, pinLowCmd, supplyCmd, porCmd, sawRst} = '0;
        {sleepMode, resetInstrExec, watchdogTimeout, clearWatchdogInstr, haltInstr, powerupTimerEn} = '0;
        {extResetPinEn, brownoutCfg} = 3'b101;
        cyc(6); rst_n <= 1'b1; wait_run(20);
        t_regs(); t_cfg(); t_pin(); t_flags(); t_bor(); t_por();
        conclude();
    end
endmodule : tb_top
